// ===== logic/dtc_consts.svh
// Constants for the dual timer/counter block: register offsets, field positions, timing.
// Assumes inclusion by bare name from the package and design modules.
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH
`define DTC_ADDR_RUN_FLAGS 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_T0_LOW 8'h8a
`define DTC_ADDR_T1_LOW 8'h8b
`define DTC_ADDR_T0_HIGH 8'h8c
`define DTC_ADDR_T1_HIGH 8'h8d
`define DTC_RESET_BYTE 8'h00
`define DTC_BIT_T1_OVF 7
`define DTC_BIT_T1_RUN 6
`define DTC_BIT_T0_OVF 5
`define DTC_BIT_T0_RUN 4
`define DTC_BIT_IRQ1_FLAG 3
`define DTC_BIT_IRQ1_TYPE 2
`define DTC_BIT_IRQ0_FLAG 1
`define DTC_BIT_IRQ0_TYPE 0
`define DTC_PER_CYCLE_CLOCKS 6
`define DTC_PRESCALE_MASK 8'h1f
`endif

// ===== logic/dtc_pkg.sv
// Types shared by the dual timer/counter block.
// Assumes the constants header is on the include path.
`include "dtc_consts.svh"
package dtc_pkg;
	// Mode select encoding of each timer
	typedef enum logic [1:0] {
		DTC_MODE_13BIT = 2'h0,
		DTC_MODE_16BIT = 2'h1,
		DTC_MODE_RELOAD = 2'h2,
		DTC_MODE_SPLIT = 2'h3
	} dtc_mode_e;
endpackage : dtc_pkg

// ===== logic/dtc_timers.sv
// Dual timer/counter with control, mode and count registers in the core's register space.
// Assumes a single-cycle register port from the core and asynchronous pins for counts and irqs.
`include "dtc_consts.svh"

// Behaviour
// RULE_01: Mode 0 is 13-bit: five-bit prescaler in low byte steps high byte.
// RULE_02: Mode 1 chains low and high bytes into one 16-bit counter.
// RULE_03: Mode 2 reloads low byte from high byte on overflow, sets flag.
// RULE_04: Software may rewrite high byte anytime; next reload uses it.
// RULE_05: Overflow sets flag; hardware clears it when the core vectors.
// RULE_06: Timer 0 mode 3: low byte is its own 8-bit timer.
// RULE_07: Timer 0 mode 3: high byte counts clock/6, uses timer 1 run/flag.
// RULE_08: Timer 1 mode 3 halts it and keeps its count.
// RULE_09: Timer 1 matches timer 0, using upper mode bits and control bits 2,3,6,7.
// RULE_10: Run bit enables counting; with gate set the irq pin also gates.
// RULE_11: Rolling from all ones to zero sets flag and requests interrupt.
// RULE_12: Timer interrupt needs its own enable and the global enable.
// RULE_13: Control register at 88h with documented bit order, resets to zero.
// RULE_14: Irq flags set on detection; cleared on service only in edge mode.
// RULE_15: Type bit clear means low level, set means falling edge.
// RULE_16: Software stops a timer before changing its mode.
// RULE_17: Timer 1 overflow is offered to the serial port as baud clock.
// RULE_18: With gating, count only while irq pin high and run set.
// RULE_19: Timer operation steps once every six clocks.
// RULE_20: Counter input sampled each peripheral cycle; high-then-low steps count.
// RULE_21: Mode bits: 00 13-bit, 01 16-bit, 10 reload, 11 split or halt.
module dtc_timers
	import dtc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic count_pin0,
	input wire logic count_pin1,
	input wire logic ext_irq0_pin_n,
	input wire logic ext_irq1_pin_n,
	input wire logic timer_irq_enable0,
	input wire logic timer_irq_enable1,
	input wire logic global_irq_enable,
	input wire logic t0_vector_ack,
	input wire logic t1_vector_ack,
	input wire logic ext_irq0_ack,
	input wire logic ext_irq1_ack,
	output logic t0_irq_req,
	output logic t1_irq_req,
	output logic ext_irq0_req,
	output logic ext_irq1_req,
	output logic baud_tick
);
	import dtc_pkg::*;
	logic [7:0] timer_run_and_flags_ff;
	logic [7:0] timer_mode_select_reg_ff;
	logic [7:0] nxt_run_flags;
	logic [2:0] per_div_ff;
	logic [1:0] cnt0_sync_ff;
	logic [1:0] cnt1_sync_ff;
	logic [1:0] irq0_sync_ff;
	logic [1:0] irq1_sync_ff;
	logic cnt0_sample_ff;
	logic cnt1_sample_ff;
	logic irq0_prev_ff;
	logic irq1_prev_ff;
	logic [7:0] t0_count_low;
	logic [7:0] t0_count_high;
	logic [7:0] t1_count_low;
	logic [7:0] t1_count_high;
	logic t0_ovf_low;
	logic t0_ovf_high;
	logic t1_ovf_low;
	logic t1_ovf_high;

	// Mode register fields
	wire logic t1_pin_gating = timer_mode_select_reg_ff[7];
	wire logic t1_count_source_select = timer_mode_select_reg_ff[6];
	wire dtc_mode_e t1_mode = dtc_mode_e'(timer_mode_select_reg_ff[5:4]); // [RULE_21]
	wire logic t0_pin_gating = timer_mode_select_reg_ff[3];
	wire logic t0_count_source_select = timer_mode_select_reg_ff[2];
	wire dtc_mode_e t0_mode = dtc_mode_e'(timer_mode_select_reg_ff[1:0]); // [RULE_21]
	wire logic t1_run_bit = timer_run_and_flags_ff[`DTC_BIT_T1_RUN];
	wire logic t0_run_bit = timer_run_and_flags_ff[`DTC_BIT_T0_RUN];
	wire logic ext_irq1_type = timer_run_and_flags_ff[`DTC_BIT_IRQ1_TYPE];
	wire logic ext_irq0_type = timer_run_and_flags_ff[`DTC_BIT_IRQ0_TYPE];

	// Peripheral cycle strobe: one pulse per six clocks
	wire logic per_tick = (per_div_ff == 3'(`DTC_PER_CYCLE_CLOCKS - 1)); // [RULE_19]
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			per_div_ff <= 3'h0;
		else
			per_div_ff <= per_tick ? 3'h0 : per_div_ff + 3'h1;
	end

	// Pin synchronisers; only the second stage is ever looked at
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt0_sync_ff <= 2'h0;
			cnt1_sync_ff <= 2'h0;
			irq0_sync_ff <= 2'h3;
			irq1_sync_ff <= 2'h3;
		end else begin
			cnt0_sync_ff <= {cnt0_sync_ff[0], count_pin0};
			cnt1_sync_ff <= {cnt1_sync_ff[0], count_pin1};
			irq0_sync_ff <= {irq0_sync_ff[0], ext_irq0_pin_n};
			irq1_sync_ff <= {irq1_sync_ff[0], ext_irq1_pin_n};
		end
	end

	// Samples for edge detection: count pins once per peripheral cycle, irq pins every clock
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt0_sample_ff <= 1'b0;
			cnt1_sample_ff <= 1'b0;
			irq0_prev_ff <= 1'b1;
			irq1_prev_ff <= 1'b1;
		end else begin
			irq0_prev_ff <= irq0_sync_ff[1];
			irq1_prev_ff <= irq1_sync_ff[1];
			if (per_tick) begin
				cnt0_sample_ff <= cnt0_sync_ff[1];
				cnt1_sample_ff <= cnt1_sync_ff[1];
			end
		end
	end

	// Counter input: previous sample high, current low, at a peripheral cycle
	wire logic cnt0_fall = per_tick && cnt0_sample_ff && !cnt0_sync_ff[1]; // [RULE_20]
	wire logic cnt1_fall = per_tick && cnt1_sample_ff && !cnt1_sync_ff[1]; // [RULE_20]
	wire logic t0_input = t0_count_source_select ? cnt0_fall : per_tick;
	wire logic t1_input = t1_count_source_select ? cnt1_fall : per_tick;
	// Gating lets the irq pin hold a timer off while it is low
	wire logic t0_enable = t0_run_bit && (!t0_pin_gating || irq0_sync_ff[1]); // [RULE_10] [RULE_18]
	wire logic t1_enable = t1_run_bit && (!t1_pin_gating || irq1_sync_ff[1]); // [RULE_10] [RULE_18]
	wire logic t0_split = (t0_mode == DTC_MODE_SPLIT);
	// In split mode timer 1 loses its run bit, so only mode 3 can stop it
	wire logic t1_run_eff = t0_split ? 1'b1 : t1_enable; // [RULE_08]
	wire logic t0_high_step = t0_split && t1_run_bit && per_tick; // [RULE_07]
	// Named low-byte step of timer 0, shared by the unit and the checks
	wire logic t0_step = t0_input && t0_enable; // [RULE_10]

	// Register write decode
	wire logic wr_ctrl = reg_wr && (reg_addr == `DTC_ADDR_RUN_FLAGS);
	wire logic wr_mode = reg_wr && (reg_addr == `DTC_ADDR_MODE);
	wire logic wr_t0_low = reg_wr && (reg_addr == `DTC_ADDR_T0_LOW);
	wire logic wr_t1_low = reg_wr && (reg_addr == `DTC_ADDR_T1_LOW);
	wire logic wr_t0_high = reg_wr && (reg_addr == `DTC_ADDR_T0_HIGH);
	wire logic wr_t1_high = reg_wr && (reg_addr == `DTC_ADDR_T1_HIGH);

	dtc_unit u_timer0 (
		.clock(clock),
		.rst(rst),
		.mode(t0_mode),
		.step_low(t0_step), // [RULE_06]
		.step_high(t0_high_step),
		.halt(1'b0),
		.wr_low(wr_t0_low),
		.wr_high(wr_t0_high),
		.wr_data(reg_wdata),
		.count_low_ff(t0_count_low),
		.count_high_ff(t0_count_high),
		.ovf_low(t0_ovf_low),
		.ovf_high(t0_ovf_high)
	);

	dtc_unit u_timer1 (
		.clock(clock),
		.rst(rst),
		.mode(t1_mode),
		.step_low(t1_input && t1_run_eff), // [RULE_09]
		.step_high(1'b0),
		.halt(t1_mode == DTC_MODE_SPLIT), // [RULE_08]
		.wr_low(wr_t1_low),
		.wr_high(wr_t1_high),
		.wr_data(reg_wdata),
		.count_low_ff(t1_count_low),
		.count_high_ff(t1_count_high),
		.ovf_low(t1_ovf_low),
		.ovf_high(t1_ovf_high)
	);

	// Overflow events; in split mode timer 0's high byte owns timer 1's flag
	wire logic t0_ovf = t0_split ? t0_ovf_low : (t0_ovf_low || t0_ovf_high); // [RULE_11]
	wire logic t1_ovf_own = t1_ovf_low || t1_ovf_high;
	wire logic t1_flag_set = t0_split ? t0_ovf_high : t1_ovf_own; // [RULE_07] [RULE_11]
	assign baud_tick = t1_ovf_own; // [RULE_17]
	// Falling edge or low level on each irq pin
	wire logic irq0_edge = irq0_prev_ff && !irq0_sync_ff[1];
	wire logic irq1_edge = irq1_prev_ff && !irq1_sync_ff[1];
	wire logic irq0_detect = ext_irq0_type ? irq0_edge : !irq0_sync_ff[1]; // [RULE_15]
	wire logic irq1_detect = ext_irq1_type ? irq1_edge : !irq1_sync_ff[1]; // [RULE_15]

	// Control register next value: software write, then hardware clears, then sets win
	always_comb begin
		nxt_run_flags = timer_run_and_flags_ff;
		if (wr_ctrl)
			nxt_run_flags = reg_wdata;
		if (t1_vector_ack)
			nxt_run_flags[`DTC_BIT_T1_OVF] = 1'b0; // [RULE_05]
		if (t0_vector_ack)
			nxt_run_flags[`DTC_BIT_T0_OVF] = 1'b0; // [RULE_05]
		if (ext_irq1_ack && ext_irq1_type)
			nxt_run_flags[`DTC_BIT_IRQ1_FLAG] = 1'b0; // [RULE_14]
		if (ext_irq0_ack && ext_irq0_type)
			nxt_run_flags[`DTC_BIT_IRQ0_FLAG] = 1'b0; // [RULE_14]
		if (t1_flag_set)
			nxt_run_flags[`DTC_BIT_T1_OVF] = 1'b1; // [RULE_05]
		if (t0_ovf)
			nxt_run_flags[`DTC_BIT_T0_OVF] = 1'b1; // [RULE_05]
		if (irq1_detect)
			nxt_run_flags[`DTC_BIT_IRQ1_FLAG] = 1'b1; // [RULE_14]
		if (irq0_detect)
			nxt_run_flags[`DTC_BIT_IRQ0_FLAG] = 1'b1; // [RULE_14]
	end

	// Control and mode registers; mode changes are not guarded, software stops first
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			timer_run_and_flags_ff <= `DTC_RESET_BYTE; // [RULE_13]
			timer_mode_select_reg_ff <= `DTC_RESET_BYTE;
		end else begin
			timer_run_and_flags_ff <= nxt_run_flags; // [RULE_13]
			if (wr_mode)
				timer_mode_select_reg_ff <= reg_wdata; // [RULE_16]
		end
	end

	// Interrupt requests; timer ones need their own and the global enable, external ones need no enable
	assign t0_irq_req = timer_run_and_flags_ff[`DTC_BIT_T0_OVF] && timer_irq_enable0
		&& global_irq_enable; // [RULE_12]
	assign t1_irq_req = timer_run_and_flags_ff[`DTC_BIT_T1_OVF] && timer_irq_enable1
		&& global_irq_enable; // [RULE_12]
	assign ext_irq0_req = timer_run_and_flags_ff[`DTC_BIT_IRQ0_FLAG];
	assign ext_irq1_req = timer_run_and_flags_ff[`DTC_BIT_IRQ1_FLAG];

	// Read mux; unmapped addresses read zero
	always_comb begin
		case (reg_addr)
			`DTC_ADDR_RUN_FLAGS: reg_rdata = timer_run_and_flags_ff;
			`DTC_ADDR_MODE: reg_rdata = timer_mode_select_reg_ff;
			`DTC_ADDR_T0_LOW: reg_rdata = t0_count_low;
			`DTC_ADDR_T1_LOW: reg_rdata = t1_count_low;
			`DTC_ADDR_T0_HIGH: reg_rdata = t0_count_high;
			`DTC_ADDR_T1_HIGH: reg_rdata = t1_count_high;
			default: reg_rdata = 8'h00;
		endcase
	end

	// Checks
	timer_tick_a: assert property (@(posedge clock) disable iff (rst) // [RULE_19]
		per_tick |=> !per_tick [*5] ##1 per_tick)
		else $error("peripheral tick spacing wrong");
	reload_val_a: assert property (@(posedge clock) disable iff (rst) // [RULE_03]
		(t0_mode == DTC_MODE_RELOAD && t0_ovf_low && !wr_t0_low)
		|=> t0_count_low == $past(t0_count_high))
		else $error("mode 2 reload value wrong");
	ovf_flag_a: assert property (@(posedge clock) disable iff (rst) // [RULE_05]
		t0_ovf |=> timer_run_and_flags_ff[`DTC_BIT_T0_OVF])
		else $error("timer 0 flag not set on overflow");
	halt_hold_a: assert property (@(posedge clock) disable iff (rst) // [RULE_08]
		(t1_mode == DTC_MODE_SPLIT && !wr_t1_low && !wr_t1_high)
		|=> $stable(t1_count_low) && $stable(t1_count_high))
		else $error("halted timer 1 moved");
	gate_hold_a: assert property (@(posedge clock) disable iff (rst) // [RULE_18]
		(t0_pin_gating && !irq0_sync_ff[1] && !wr_t0_low && !t0_split)
		|=> $stable(t0_count_low))
		else $error("gated timer 0 counted");
	irq_enable_a: assert property (@(posedge clock) disable iff (rst) // [RULE_12]
		t0_irq_req |-> global_irq_enable && timer_irq_enable0)
		else $error("timer irq without enables");
	level_hold_a: assert property (@(posedge clock) disable iff (rst) // [RULE_14]
		(!ext_irq0_type && timer_run_and_flags_ff[`DTC_BIT_IRQ0_FLAG] && !wr_ctrl)
		|=> timer_run_and_flags_ff[`DTC_BIT_IRQ0_FLAG])
		else $error("level irq flag cleared by hardware");
	split_flag_a: assert property (@(posedge clock) disable iff (rst) // [RULE_07]
		(t0_split && t0_ovf_high) |=> timer_run_and_flags_ff[`DTC_BIT_T1_OVF])
		else $error("split high byte did not set timer 1 flag");
	carry_chain_a: assert property (@(posedge clock) disable iff (rst) // [RULE_02]
		(t0_mode == DTC_MODE_16BIT && t0_count_low == 8'hff && t0_step && !wr_t0_low
		&& !wr_t0_high)
		|=> t0_count_low == 8'h00 && t0_count_high == $past(t0_count_high) + 8'h01)
		else $error("16-bit carry into high byte wrong");
	prescale_carry_a: assert property (@(posedge clock) disable iff (rst) // [RULE_01]
		(t0_mode == DTC_MODE_13BIT && t0_count_low[4:0] == 5'h1f && t0_step && !wr_t0_low
		&& !wr_t0_high)
		|=> t0_count_low[4:0] == 5'h00 && t0_count_high == $past(t0_count_high) + 8'h01)
		else $error("prescaler carry into high byte wrong");
	split_low_a: assert property (@(posedge clock) disable iff (rst) // [RULE_06]
		(t0_split && !t0_step && !wr_t0_low) |=> $stable(t0_count_low))
		else $error("split low byte moved without its own step");
	split_high_a: assert property (@(posedge clock) disable iff (rst) // [RULE_07]
		(t0_split && !t1_run_bit && !wr_t0_high) |=> $stable(t0_count_high))
		else $error("split high byte ran without timer 1 run bit");
	baud_flag_a: assert property (@(posedge clock) disable iff (rst) // [RULE_17]
		(baud_tick && !t0_split) |=> timer_run_and_flags_ff[`DTC_BIT_T1_OVF])
		else $error("baud tick without timer 1 flag");
	t1_reload_a: assert property (@(posedge clock) disable iff (rst) // [RULE_09]
		(t1_mode == DTC_MODE_RELOAD && t1_ovf_low && !wr_t1_low)
		|=> t1_count_low == $past(t1_count_high))
		else $error("timer 1 reload value wrong");
	t1_gate_a: assert property (@(posedge clock) disable iff (rst) // [RULE_18]
		(t1_pin_gating && !irq1_sync_ff[1] && !wr_t1_low && !t0_split)
		|=> $stable(t1_count_low))
		else $error("gated timer 1 counted");
	edge_only_a: assert property (@(posedge clock) disable iff (rst) // [RULE_15]
		(ext_irq0_type && !irq0_edge && !wr_ctrl
		&& !timer_run_and_flags_ff[`DTC_BIT_IRQ0_FLAG])
		|=> !timer_run_and_flags_ff[`DTC_BIT_IRQ0_FLAG])
		else $error("edge mode irq flag set without a falling edge");
	level_set_a: assert property (@(posedge clock) disable iff (rst) // [RULE_15]
		(!ext_irq0_type && !irq0_sync_ff[1]) |=> timer_run_and_flags_ff[`DTC_BIT_IRQ0_FLAG])
		else $error("level irq flag not set while pin low");
	count_edge_a: assert property (@(posedge clock) disable iff (rst) // [RULE_20]
		(t0_count_source_select && !cnt0_fall && !wr_t0_low) |=> $stable(t0_count_low))
		else $error("counter moved without a falling edge");
endmodule : dtc_timers

// ===== logic/dtc_unit.sv
// One timer/counter channel: low and high count bytes in modes 0, 1, 2 and 3.
// Assumes one-cycle step enables from the parent and byte writes from the core.
`include "dtc_consts.svh"
module dtc_unit
	import dtc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire dtc_pkg::dtc_mode_e mode,
	input wire logic step_low,
	input wire logic step_high,
	input wire logic halt,
	input wire logic wr_low,
	input wire logic wr_high,
	input wire logic [7:0] wr_data,
	output logic [7:0] count_low_ff,
	output logic [7:0] count_high_ff,
	output logic ovf_low,
	output logic ovf_high
);
	import dtc_pkg::*;
	logic [7:0] nxt_count_low;
	logic [7:0] nxt_count_high;
	wire logic low_all_ones = (count_low_ff == 8'hff);
	wire logic pre_all_ones = ((count_low_ff & `DTC_PRESCALE_MASK) == `DTC_PRESCALE_MASK);
	wire logic high_all_ones = (count_high_ff == 8'hff);
	wire logic run = step_low && !halt;
	// Carry out of the low part: five-bit prescaler in mode 0, full byte otherwise
	wire logic carry_low = run && ((mode == DTC_MODE_13BIT) ? pre_all_ones : low_all_ones);
	wire logic bump_high = (mode == DTC_MODE_SPLIT) ? step_high :
		(carry_low && (mode != DTC_MODE_RELOAD));
	// Low byte wraps as a whole; in mode 0 the upper three bits just ride along
	assign ovf_low = carry_low && (mode == DTC_MODE_RELOAD || mode == DTC_MODE_SPLIT);
	assign ovf_high = bump_high && high_all_ones;

	// Next count values; a core write beats counting in the same cycle
	always_comb begin
		nxt_count_low = count_low_ff;
		nxt_count_high = count_high_ff;
		if (run) begin
			if (mode == DTC_MODE_RELOAD && low_all_ones)
				nxt_count_low = count_high_ff; // [RULE_03] [RULE_04]
			else
				nxt_count_low = count_low_ff + 8'h01; // [RULE_01] [RULE_02]
		end
		if (bump_high)
			nxt_count_high = count_high_ff + 8'h01; // [RULE_01] [RULE_02]
		if (wr_low)
			nxt_count_low = wr_data;
		if (wr_high)
			nxt_count_high = wr_data;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count_low_ff <= `DTC_RESET_BYTE;
			count_high_ff <= `DTC_RESET_BYTE;
		end else begin
			count_low_ff <= nxt_count_low;
			count_high_ff <= nxt_count_high;
		end
	end
endmodule : dtc_unit

// ===== verification/dtc_core_model.sv
// Core-side model: vectors to each pending request and pulses its acknowledge once.
// Assumes request levels from the timer block and a per-line enable from the bench.
module dtc_core_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic [3:0] ack_en,
	input wire logic [3:0] irq_req,
	output logic [3:0] irq_ack_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] busy_ff;
	logic [1:0] wait_ff [4];
	// Waits two cycles before vectoring, as a core finishing its instruction would
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy_ff <= 4'h0;
			irq_ack_ff <= 4'h0;
			for (int i = 0; i < 4; i++) wait_ff[i] <= 2'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				irq_ack_ff[i] <= 1'b0;
				if (!irq_req[i]) begin
					busy_ff[i] <= 1'b0;
					wait_ff[i] <= 2'h0;
				end else if (ack_en[i] && !busy_ff[i]) begin
					wait_ff[i] <= wait_ff[i] + 2'h1;
					if (wait_ff[i] == 2'h2) begin
						irq_ack_ff[i] <= 1'b1;
						busy_ff[i] <= 1'b1;
					end
				end
			end
		end
	end
endmodule : dtc_core_model

// ===== verification/dtc_timers_bench.sv
// Self-checking bench for the dual timer/counter: registers, modes, gating and irq flags.
// Assumes the core model file and the design include path; count pin 1 held idle.
`include "dtc_consts.svh"
module dtc_timers_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic count_pin0 = 1'b0;
	logic irq0_n = 1'b1;
	logic irq1_n = 1'b1;
	logic baud;
	logic glob_en = 1'b1;
	logic [3:0] ack_en = 4'h0;
	logic [3:0] irq_req;
	logic [3:0] ack;
	int err_total = 0;
	int check_count = 0;
	int cycles = 0;
	// Design and core model; count pin 1 tied idle
	dtc_timers uut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .count_pin0(count_pin0),
		.count_pin1(1'b0), .ext_irq0_pin_n(irq0_n), .ext_irq1_pin_n(irq1_n),
		.timer_irq_enable0(1'b1), .timer_irq_enable1(1'b1), .global_irq_enable(glob_en),
		.t0_vector_ack(ack[0]), .t1_vector_ack(ack[1]), .ext_irq0_ack(ack[2]),
		.ext_irq1_ack(ack[3]), .t0_irq_req(irq_req[0]), .t1_irq_req(irq_req[1]),
		.ext_irq0_req(irq_req[2]), .ext_irq1_req(irq_req[3]), .baud_tick(baud));
	dtc_core_model core (.clock(clock), .rst(rst), .ack_en(ack_en), .irq_req(irq_req),
		.irq_ack_ff(ack));
	// Clock and hang guard; whole run needs well under 3000 cycles
	initial begin
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		if (err_total == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// One-cycle write strobe, launched just after an edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#2;
		reg_addr = a;
		reg_wr = 1'b1;
		reg_wdata = d;
		@(posedge clock);
		#2;
		reg_wr = 1'b0;
	endtask : wr
	task automatic chk_reg(input string name, input logic [7:0] a, input logic [7:0] exp);
		reg_addr = a;
		#1;
		chk(name, exp, reg_rdata);
	endtask : chk_reg
	// Polls each cycle until the masked bits match; running out counts as a mismatch
	task automatic wait_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v,
		input int lim);
		for (int i = 0; i < lim; i++) begin
			reg_addr = a;
			#1;
			if ((reg_rdata & m) === v) return;
			@(posedge clock);
			#2;
		end
		err_total++;
		$display("Error wait at %h expected %h seen %h", a, v, reg_rdata & m);
	endtask : wait_reg
	task automatic t_reset();
		for (int a = 136; a <= 142; a++) begin
			chk_reg("reset byte", 8'(a), `DTC_RESET_BYTE);
		end
		wr(8'h88, 8'h5a);
		chk_reg("control layout", 8'h88, 8'h5a);
		wr(8'h88, 8'h00);
	endtask : t_reset
	task automatic t_mode1();
		int n;
		wr(8'h89, 8'h01);
		wr(8'h8a, 8'hff);
		wr(8'h8c, 8'hff);
		wr(8'h88, 8'h10);
		wait_reg(8'h88, 8'h20, 8'h20, 20);
		chk_reg("t0 low", 8'h8a, 8'h00);
		chk_reg("t0 high", 8'h8c, 8'h00);
		chk("t0 req", 8'h01, {7'h00, irq_req[0]});
		glob_en = 1'b0;
		#1;
		chk("t0 req masked", 8'h00, {7'h00, irq_req[0]});
		glob_en = 1'b1;
		ack_en = 4'h1;
		wait_reg(8'h88, 8'h20, 8'h00, 10);
		wait_reg(8'h8a, 8'hff, 8'h02, 20);
		n = cycles;
		wait_reg(8'h8a, 8'hff, 8'h03, 10);
		chk("tick spacing", 8'h06, 8'(cycles - n));
		wr(8'h88, 8'h00);
	endtask : t_mode1
	task automatic t_mode2();
		wr(8'h89, 8'h02);
		wr(8'h8c, 8'hf0);
		wr(8'h8a, 8'hfe);
		wr(8'h88, 8'h10);
		wait_reg(8'h88, 8'h20, 8'h20, 30);
		chk_reg("reload low", 8'h8a, 8'hf0);
		chk_reg("reload high", 8'h8c, 8'hf0);
		wr(8'h8c, 8'h80);
		wait_reg(8'h88, 8'h20, 8'h00, 10);
		wait_reg(8'h88, 8'h20, 8'h20, 200);
		chk_reg("new reload", 8'h8a, 8'h80);
		wr(8'h88, 8'h00);
	endtask : t_mode2
	task automatic t_mode0();
		wr(8'h89, 8'h00);
		wr(8'h8c, 8'h00);
		wr(8'h8a, 8'h1e);
		wr(8'h88, 8'h10);
		wait_reg(8'h8a, 8'h1f, 8'h1f, 10);
		chk_reg("no early carry", 8'h8c, 8'h00);
		wait_reg(8'h8c, 8'hff, 8'h01, 10);
		reg_addr = 8'h8a;
		#1;
		chk("prescaler", 8'h00, reg_rdata & `DTC_PRESCALE_MASK);
		wr(8'h88, 8'h00);
	endtask : t_mode0
	task automatic t_gate_count();
		wr(8'h89, 8'h09);
		wr(8'h8a, 8'h00);
		irq0_n = 1'b0;
		wr(8'h88, 8'h10);
		repeat (30) @(posedge clock);
		#2;
		chk_reg("gated low", 8'h8a, 8'h00);
		irq0_n = 1'b1;
		wait_reg(8'h8a, 8'hff, 8'h01, 20);
		wr(8'h88, 8'h00);
		wr(8'h89, 8'h05);
		wr(8'h8a, 8'h00);
		wr(8'h88, 8'h10);
		repeat (3) begin
			count_pin0 = 1'b1;
			repeat (20) @(posedge clock);
			#2 count_pin0 = 1'b0;
			repeat (20) @(posedge clock);
			#2;
		end
		chk_reg("falling edges", 8'h8a, 8'h03);
		wr(8'h88, 8'h00);
	endtask : t_gate_count
	// Timer 1 in auto-reload as baud source, then gated by its irq pin
	task automatic t_timer1();
		int n;
		wr(8'h89, 8'h20);
		wr(8'h8d, 8'hfe);
		wr(8'h8b, 8'hfe);
		wr(8'h88, 8'h40);
		wait_reg(8'h88, 8'h80, 8'h80, 30);
		chk_reg("t1 reload", 8'h8b, 8'hfe);
		chk("t1 req", 8'h01, {7'h00, irq_req[1]});
		n = 0;
		repeat (24) begin
			@(posedge clock);
			#2;
			n += int'(baud);
		end
		chk("baud ticks", 8'h02, 8'(n));
		wr(8'h88, 8'h00);
		wr(8'h89, 8'h90);
		wr(8'h8b, 8'h00);
		irq1_n = 1'b0;
		wr(8'h88, 8'h40);
		repeat (20) @(posedge clock);
		#2;
		chk_reg("t1 gated", 8'h8b, 8'h00);
		irq1_n = 1'b1;
		wait_reg(8'h8b, 8'hff, 8'h01, 20);
		wr(8'h88, 8'h00);
	endtask : t_timer1
	task automatic t_split();
		wr(8'h8b, 8'h55);
		wr(8'h8a, 8'h77);
		wr(8'h8c, 8'hfe);
		wr(8'h89, 8'h33);
		wr(8'h88, 8'h40);
		wait_reg(8'h88, 8'h80, 8'h80, 30);
		chk_reg("split high", 8'h8c, 8'h00);
		chk_reg("split low idle", 8'h8a, 8'h77);
		chk_reg("halted t1", 8'h8b, 8'h55);
		wr(8'h88, 8'h00);
	endtask : t_split
	task automatic t_ext_irq();
		wr(8'h88, 8'h01);
		irq0_n = 1'b0;
		wait_reg(8'h88, 8'h02, 8'h02, 10);
		chk("ext req", 8'h01, {7'h00, irq_req[2]});
		irq0_n = 1'b1;
		ack_en = 4'h4;
		wait_reg(8'h88, 8'h02, 8'h00, 10);
		ack_en = 4'h0;
		wr(8'h88, 8'h00);
		irq0_n = 1'b0;
		wait_reg(8'h88, 8'h02, 8'h02, 10);
		// Pin released before the ack, so only the ack could clear the level flag
		irq0_n = 1'b1;
		repeat (3) @(posedge clock);
		#2 ack_en = 4'h4;
		repeat (10) @(posedge clock);
		#2;
		chk_reg("level flag kept", 8'h88, 8'h02);
	endtask : t_ext_irq
	// Main sequence: reset for five cycles, then each scenario in turn
	initial begin
		repeat (5) @(posedge clock);
		#2 rst = 1'b0;
		t_reset();
		t_mode1();
		t_mode2();
		t_mode0();
		t_gate_count();
		t_timer1();
		t_split();
		t_ext_irq();
		print_verdict();
	end
endmodule : dtc_timers_bench
